// File: verilog/odd_top.sv
// orientation detect: portrait/landscape, back/front, z lockout, debounced interrupt
// assumes angle inputs and config ports come from logic on i_clk, i_sample marks a new
// output sample for one cycle
//
// Operation
// - disabled means no results and no interrupt
// - z tilt past lockout freezes orientation changes
// - back/front decided by configurable z trip angle
// - midpoint measured from X, right down, left up
// - thresholds are midpoint plus or minus hysteresis
// - interrupt only after the debounce time elapses
// - decrement mode steps counter down on failure
// - clear mode zeroes counter on failure
// - current trip angles readable as outputs
module odd_top
    import odd_pkg::*;
#(
    parameter int DB_W = ODD_DB_W_DEF
) (
    input wire logic i_clk,                  // 200 MHz system clock
    input wire logic i_rst,                  // async reset, active high
    input wire logic i_ce,                   // clock enable, low freezes state
    input wire logic i_sample,               // output sample strobe
    input wire logic i_pl_en,                // orientation detection enable
    input wire logic [ANG_W-1:0] i_xy_angle, // gravity angle from X axis in XY plane
    input wire logic i_x_neg,                // gravity on negative X
    input wire logic i_y_neg,                // gravity on negative Y
    input wire logic [ANG_W-1:0] i_z_angle,  // z tilt angle
    input wire logic i_z_neg,                // gravity on negative Z
    input wire logic [ANG_W-1:0] i_zlock,    // z lockout angle
    input wire logic [ANG_W-1:0] i_bf_trip,  // back/front trip angle
    input wire logic [ANG_W-1:0] i_pl_mid,   // portrait/landscape midpoint
    input wire logic [ANG_W-1:0] i_hyst,     // hysteresis angle
    input wire logic [DB_W-1:0] i_db_limit,  // debounce count in samples
    input wire logic i_db_clear,             // 1 clear mode, 0 decrement mode
    input wire logic i_int_ack,              // clears the interrupt flag
    output logic [3:0] o_orient,             // one-hot orientation
    output logic o_back,                     // facing back
    output logic o_lockout,                  // z lockout in effect
    output logic o_valid,                    // results valid
    output logic o_int,                      // orientation change flag
    output logic [ANG_W-1:0] o_pl_trip,      // effective portrait-to-landscape angle
    output logic [ANG_W-1:0] o_lp_trip,      // effective landscape-to-portrait angle
    output logic [DB_W-1:0] o_db_count       // debounce counter value
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (DB_W < 1 || DB_W > ODD_DB_W_MAX) begin : g_bad_width
        $error("DB_W out of range");
    end

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    function automatic odd_orient_e classify(odd_orient_e cur, odd_ang_t xy, logic xn,
                                             logic yn, odd_ang_t pl, odd_ang_t lp);
        logic is_land;
        logic land_next;
        is_land = 1'b0;
        unique case (cur)
            OR_PORT_UP, OR_PORT_DN: is_land = 1'b0;
            OR_LAND_RT, OR_LAND_LT: is_land = 1'b1;
            default: is_land = 1'b0;
        endcase
        land_next = is_land ? (xy <= lp) : (xy < pl);
        if (land_next) begin
            return xn ? OR_LAND_LT : OR_LAND_RT;
        end
        return yn ? OR_PORT_DN : OR_PORT_UP;
    endfunction

    odd_orient_e orient_reg;
    odd_orient_e cand_reg;
    odd_orient_e cand;
    odd_orient_e cur_orient;
    logic locked;

    assign locked = i_z_angle > i_zlock;
    assign cand = classify(cur_orient, i_xy_angle, i_x_neg, i_y_neg, o_pl_trip, o_lp_trip);

    // ------------------------------------------------------------
    // debounce counter
    // ------------------------------------------------------------
    odd_db_if #(.DB_W(DB_W)) db ();

    // a pending fire sets the orientation a back-to-back sample is judged against
    assign cur_orient = (db.fire && i_pl_en) ? cand_reg : orient_reg;
    assign db.sample = i_sample && i_pl_en && !locked;
    assign db.differs = cand != cur_orient;
    assign db.mode_clear = i_db_clear;
    assign db.limit = i_db_limit;
    assign o_db_count = db.count;

    odd_debounce #(.DB_W(DB_W)) u_debounce (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .db(db)
    );

    // ------------------------------------------------------------
    // trip angles
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pl_trip <= ODD_ANG_ZERO;
            o_lp_trip <= ODD_ANG_ZERO;
        end else if (i_ce) begin
            o_pl_trip <= odd_sat_sub(i_pl_mid, i_hyst);
            o_lp_trip <= odd_sat_add(i_pl_mid, i_hyst);
        end
    end

    // ------------------------------------------------------------
    // candidate and accepted orientation
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cand_reg <= ODD_ORIENT_RST;
        end else if (i_ce && db.sample) begin
            cand_reg <= cand;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            orient_reg <= ODD_ORIENT_RST;
        end else if (i_ce && db.fire && i_pl_en) begin
            orient_reg <= cand_reg;
        end
    end

    assign o_orient = orient_reg;

    // ------------------------------------------------------------
    // back/front and lockout
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_back <= ODD_BACK_RST;
        end else if (i_ce && i_sample && i_pl_en && i_z_angle >= i_bf_trip) begin
            o_back <= i_z_neg;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_lockout <= 1'b0;
        end else if (i_ce) begin
            if (!i_pl_en) begin
                o_lockout <= 1'b0;
            end else if (i_sample) begin
                o_lockout <= locked;
            end
        end
    end

    // ------------------------------------------------------------
    // valid and interrupt flag
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else if (i_ce) begin
            if (!i_pl_en) begin
                o_valid <= 1'b0;
            end else if (i_sample) begin
                o_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int <= 1'b0;
        end else if (i_ce) begin
            if (!i_pl_en) begin
                o_int <= 1'b0;
            end else if (db.fire) begin
                o_int <= 1'b1;
            end else if (i_int_ack) begin
                o_int <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_disabled_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_pl_en) |=> (!o_valid && !o_int))
        else $error("results or interrupt while detection disabled");

    a_lockout_no_count: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sample && i_pl_en && locked) |=> (o_db_count == $past(o_db_count)))
        else $error("debounce stepped during z lockout");

    a_lockout_shown: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sample && i_pl_en) |=> (o_lockout == $past(locked)))
        else $error("lockout status does not follow the z tilt");

    a_ack_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_pl_en && !db.fire && i_int_ack) |=> !o_int)
        else $error("acknowledge did not clear the interrupt flag");

    a_trip_angles: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_rst) |=> (o_lp_trip == odd_sat_add($past(i_pl_mid), $past(i_hyst))
                  && o_pl_trip == odd_sat_sub($past(i_pl_mid), $past(i_hyst))))
        else $error("trip angles do not match midpoint and hysteresis");

    a_back_class: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sample && i_pl_en && i_z_angle >= i_bf_trip) |=> (o_back == $past(i_z_neg)))
        else $error("back/front classification wrong");

    a_int_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_pl_en && db.fire) |=> o_int)
        else $error("orientation change lost its interrupt");

    a_orient_update: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_pl_en && db.fire) |=> (o_orient == $past(cand_reg)))
        else $error("orientation not taken on debounce fire");

endmodule

// File: pkg/odd_pkg.sv
// orientation detect with debounce: shared constants, types and angle helpers
// assumes angles arrive in whole degrees, 0 to 90, on the block's own clock
package odd_pkg;

    // ------------------------------------------------------------
    // angle format
    // ------------------------------------------------------------
    localparam int ANG_W = 7;
    typedef logic [ANG_W-1:0] odd_ang_t;
    localparam odd_ang_t ODD_ANG_MAX = 7'h5a;
    localparam odd_ang_t ODD_ANG_ZERO = 7'h00;

    // ------------------------------------------------------------
    // debounce counter
    // ------------------------------------------------------------
    localparam int ODD_DB_W_DEF = 8;
    localparam int ODD_DB_W_MAX = 16;

    // ------------------------------------------------------------
    // orientation codes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OR_PORT_UP = 4'h1,
        OR_PORT_DN = 4'h2,
        OR_LAND_RT = 4'h4,
        OR_LAND_LT = 4'h8
    } odd_orient_e;

    localparam odd_orient_e ODD_ORIENT_RST = OR_PORT_UP;
    localparam logic ODD_BACK_RST = 1'b0;

    // ------------------------------------------------------------
    // saturating angle arithmetic
    // ------------------------------------------------------------
    function automatic odd_ang_t odd_sat_add(odd_ang_t a, odd_ang_t b);
        logic [ANG_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > {1'b0, ODD_ANG_MAX}) ? ODD_ANG_MAX : s[ANG_W-1:0];
    endfunction

    function automatic odd_ang_t odd_sat_sub(odd_ang_t a, odd_ang_t b);
        return (b > a) ? ODD_ANG_ZERO : odd_ang_t'(a - b);
    endfunction

endpackage

// File: pkg/odd_db_if.sv
// carrier between the orientation top and its debounce counter
// assumes both ends run on the same clock
interface odd_db_if #(parameter int DB_W = 8);
    logic sample;
    logic differs;
    logic mode_clear;
    logic [DB_W-1:0] limit;
    logic [DB_W-1:0] count;
    logic fire;

    modport ctl (output sample, output differs, output mode_clear, output limit,
                 input count, input fire);
    modport cnt (input sample, input differs, input mode_clear, input limit,
                 output count, output fire);
endinterface

// File: verilog/odd_debounce.sv
// debounce counter for orientation changes, one step per output sample
// assumes sample is a one-cycle strobe on i_clk and ce freezes all state
module odd_debounce
    import odd_pkg::*;
#(
    parameter int DB_W = ODD_DB_W_DEF
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_ce,  // clock enable
    odd_db_if.cnt db        // counter control and result
);

    // ------------------------------------------------------------
    // count and fire
    // ------------------------------------------------------------
    logic reach;
    assign reach = ({1'b0, db.count} + {{DB_W{1'b0}}, 1'b1}) >= {1'b0, db.limit};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            db.count <= '0;
            db.fire <= 1'b0;
        end else if (i_ce) begin
            db.fire <= 1'b0;
            if (db.sample) begin
                if (db.differs) begin
                    if (reach) begin
                        db.fire <= 1'b1;
                        db.count <= '0;
                    end else begin
                        db.count <= db.count + 1'b1;
                    end
                end else if (db.mode_clear) begin
                    db.count <= '0;
                end else if (db.count != '0) begin
                    db.count <= db.count - 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_clear_mode_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && db.sample && !db.differs && db.mode_clear) |=> (db.count == '0))
        else $error("clear mode did not zero the count");

    a_dec_mode_step: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && db.sample && !db.differs && !db.mode_clear && db.count != '0)
        |=> (db.count == $past(db.count) - 1'b1))
        else $error("decrement mode did not step the count down by one");

    a_fire_at_limit: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && db.sample && db.differs && reach) |=> (db.fire && db.count == '0))
        else $error("debounce did not fire at the configured count");

    a_fire_needs_count: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !(db.sample && db.differs && reach)) |=> !db.fire)
        else $error("debounce fired before the configured count");

endmodule

// File: verification/odd_host_model.sv
// host side model: enables detection outside reset and standby, acknowledges the orientation interrupt
// assumes the same clock and reset as the orientation block
module odd_host_model (
    input wire logic i_clk,               // system clock
    input wire logic i_rst,               // async reset, active high
    input wire logic i_int,               // orientation change flag from the block
    input wire logic [3:0] i_orient,      // one-hot orientation from the block
    input wire logic i_standby,           // bench asks for standby while high
    input wire logic [3:0] i_ack_dly,     // cycles to wait before acknowledging
    output logic o_pl_en,                 // detection enable towards the block
    output logic o_int_ack,               // interrupt acknowledge pulse
    output logic [3:0] o_last_orient,     // orientation read at the last interrupt
    output logic [7:0] o_int_cnt          // interrupts seen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] off_cnt_reg;
    logic [3:0] wait_reg;
    logic pend_reg;

    // ------------------------------------------------------------
    // active mode is re-entered on the third clock after reset or standby is released
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            off_cnt_reg <= 2'h2;
            o_pl_en <= 1'b0;
        end else if (i_standby) begin
            off_cnt_reg <= 2'h2;
            o_pl_en <= 1'b0;
        end else if (off_cnt_reg != 2'h0) begin
            off_cnt_reg <= off_cnt_reg - 2'h1;
        end else begin
            o_pl_en <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt service: read orientation, acknowledge after a delay
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_reg <= 1'b0;
            wait_reg <= 4'h0;
            o_int_ack <= 1'b0;
            o_last_orient <= 4'h0;
            o_int_cnt <= 8'h00;
        end else begin
            o_int_ack <= 1'b0;
            if (i_int && !pend_reg && !o_int_ack) begin
                pend_reg <= 1'b1;
                wait_reg <= i_ack_dly;
                o_last_orient <= i_orient;
                o_int_cnt <= o_int_cnt + 8'h01;
            end else if (pend_reg && wait_reg == 4'h0) begin
                pend_reg <= 1'b0;
                o_int_ack <= 1'b1;
            end else if (pend_reg) begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end
endmodule

// File: verification/testbench.sv
// self-checking bench for the orientation detector with its host model
// assumes a 200 MHz clock and no other clock domain
module testbench
    import odd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk, i_rst, i_ce, i_sample, i_x_neg, i_y_neg, i_z_neg, i_db_clear;
    logic [ANG_W-1:0] i_xy_angle, i_z_angle, i_zlock, i_bf_trip, i_pl_mid, i_hyst;
    logic [ANG_W-1:0] o_pl_trip, o_lp_trip;
    logic [7:0] i_db_limit, o_db_count, int_cnt;
    logic [3:0] o_orient, ack_dly, last_orient;
    logic pl_en, int_ack, o_back, o_lockout, o_valid, o_int, host_standby;
    int num_errors, checked;
    int cyc = 0;

    odd_top #(.DB_W(8)) u_dut (.i_clk, .i_rst, .i_ce, .i_sample, .i_pl_en(pl_en),
        .i_xy_angle, .i_x_neg, .i_y_neg, .i_z_angle, .i_z_neg, .i_zlock, .i_bf_trip,
        .i_pl_mid, .i_hyst, .i_db_limit, .i_db_clear, .i_int_ack(int_ack), .o_orient,
        .o_back, .o_lockout, .o_valid, .o_int, .o_pl_trip, .o_lp_trip, .o_db_count);

    odd_host_model u_host (.i_clk, .i_rst, .i_int(o_int), .i_orient(o_orient),
        .i_standby(host_standby), .i_ack_dly(ack_dly), .o_pl_en(pl_en),
        .o_int_ack(int_ack), .o_last_orient(last_orient), .o_int_cnt(int_cnt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic smp(input logic [ANG_W-1:0] xy);
        @(posedge i_clk);
        i_xy_angle <= xy;
        i_sample <= 1'b1;
        @(posedge i_clk);
        i_sample <= 1'b0;
        #1;
    endtask

    task automatic pos(input logic xn, input logic yn, input logic [ANG_W-1:0] z,
                       input logic zn);
        @(posedge i_clk);
        i_x_neg <= xn;
        i_y_neg <= yn;
        i_z_angle <= z;
        i_z_neg <= zn;
    endtask

    task automatic two(input logic [ANG_W-1:0] xy, input logic [3:0] exp);
        smp(xy);
        smp(xy);
        wt(1);
        chk(o_orient, exp, "orientation");
    endtask

    task automatic trip(input logic [ANG_W-1:0] mid, hyst, pl, lp);
        @(posedge i_clk);
        i_pl_mid <= mid;
        i_hyst <= hyst;
        wt(2);
        chk(o_pl_trip, pl, "portrait to landscape trip");
        chk(o_lp_trip, lp, "landscape to portrait trip");
    endtask

    task automatic give_verdict;
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fire;
        trip(7'h55, 7'h0a, 7'h4b, 7'h5a);
        trip(7'h05, 7'h0a, 7'h00, 7'h0f);
        trip(7'h2d, 7'h0a, 7'h23, 7'h37);
        smp(7'h23);
        chk(o_db_count, 16'h0, "count at trip boundary");
        smp(7'h22);
        chk(o_db_count, 16'h1, "count after one sample");
        chk(o_int, 16'h0, "early interrupt");
        smp(7'h22);
        chk(o_db_count, 16'h0, "count after firing");
        wt(1);
        chk(o_orient, 16'h4, "landscape right");
        chk(o_int, 16'h1, "interrupt after debounce");
        wt(8);
        chk(o_int, 16'h0, "interrupt acknowledged");
        chk(int_cnt, 16'h1, "host interrupt count");
        chk(last_orient, 16'h4, "host orientation");
        smp(7'h37);
        chk(o_db_count, 16'h0, "landscape held at upper trip");
        two(7'h38, 4'h1);
        pos(1'b1, 1'b0, 7'h00, 1'b0);
        two(7'h10, 4'h8);
        chk(o_int, 16'h1, "interrupt set wins over acknowledge");
        pos(1'b1, 1'b1, 7'h00, 1'b0);
        two(7'h50, 4'h2);
    endtask

    task automatic t_db;
        @(posedge i_clk);
        i_db_limit <= 8'h04;
        i_db_clear <= 1'b0;
        repeat (3) smp(7'h10);
        chk(o_db_count, 16'h3, "count after three samples");
        smp(7'h50);
        chk(o_db_count, 16'h2, "decrement on failure");
        smp(7'h50);
        chk(o_db_count, 16'h1, "second decrement");
        @(posedge i_clk);
        i_db_clear <= 1'b1;
        smp(7'h10);
        chk(o_db_count, 16'h2, "count before clear");
        smp(7'h50);
        chk(o_db_count, 16'h0, "clear on failure");
    endtask

    task automatic t_lock;
        pos(1'b1, 1'b1, 7'h50, 1'b1);
        smp(7'h10);
        chk(o_lockout, 16'h1, "lockout shown");
        chk(o_db_count, 16'h0, "locked sample ignored");
        pos(1'b1, 1'b1, 7'h41, 1'b1);
        smp(7'h10);
        chk(o_lockout, 16'h0, "lockout left");
        chk(o_db_count, 16'h1, "counting resumed");
        chk(o_back, 16'h1, "facing back");
        pos(1'b1, 1'b1, 7'h10, 1'b0);
        smp(7'h10);
        chk(o_back, 16'h1, "back held below trip");
        pos(1'b1, 1'b1, 7'h41, 1'b0);
        smp(7'h10);
        chk(o_back, 16'h0, "facing front");
        @(posedge i_clk);
        i_ce <= 1'b0;
        smp(7'h10);
        chk(o_db_count, 16'h3, "frozen without enable");
        @(posedge i_clk);
        i_ce <= 1'b1;
    endtask

    task automatic t_dis;
        @(posedge i_clk);
        ack_dly <= 4'hf;
        smp(7'h10);
        wt(1);
        chk(o_int, 16'h1, "interrupt at limit");
        @(posedge i_clk);
        host_standby <= 1'b1;
        wt(3);
        chk(o_int, 16'h0, "interrupt dropped when disabled");
        chk(o_valid, 16'h0, "no results when disabled");
        smp(7'h50);
        chk(o_db_count, 16'h0, "sample ignored when disabled");
        @(posedge i_clk);
        host_standby <= 1'b0;
        wt(4);
        smp(7'h50);
        chk(o_valid, 16'h1, "results after reactivation");
        chk(o_db_count, 16'h1, "counting after reactivation");
    endtask

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        {i_rst, i_ce, i_db_clear} = 3'h7;
        {i_sample, i_x_neg, i_y_neg, i_z_neg, host_standby} = 5'h00;
        i_xy_angle = 7'h5a;
        i_z_angle = 7'h00;
        i_zlock = 7'h46;
        i_bf_trip = 7'h3c;
        i_pl_mid = 7'h2d;
        i_hyst = 7'h0a;
        i_db_limit = 8'h02;
        ack_dly = 4'h3;
        num_errors = 0;
        checked = 0;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        wt(6);
        t_fire();
        t_db();
        t_lock();
        t_dis();
        give_verdict();
    end
endmodule
